// file: crc_chk_pkg.sv
package crc_chk_pkg;
    // ==========================================
    // Timing.
    // ==========================================
    localparam int CLK_NS       = 10;                     // Core clock period in ns.
    localparam int ALERT_PW_NS  = 100;                    // Longest error pulse on the alert line.
    localparam int ALERT_PW_CYC = ALERT_PW_NS / CLK_NS;   // Rounded down, as it is a longest time.

    // ==========================================
    // Register map (byte addresses).
    // ==========================================
    localparam logic [3:0] OFS_CTRL    = 4'h0;   // Enables and alert latency.
    localparam logic [3:0] OFS_STATUS  = 4'h4;   // Sticky error, line level, busy.
    localparam logic [3:0] OFS_READOUT = 4'h8;   // Error log page, read only.

    localparam int CTRL_CRC_EN = 0;              // Write CRC checking on.
    localparam int CTRL_MSK_EN = 1;              // Byte masking on.
    localparam int CTRL_INV_EN = 2;              // Write inversion on.
    localparam int CTRL_LAT_LO = 8;              // Low bit of the latency field.
    localparam int LAT_W       = 8;              // Width of the latency field.
    localparam int STAT_LINE   = 0;              // Synchronised alert line level.
    localparam int STAT_BUSY   = 1;              // Error report under way.
    localparam int STAT_ERR    = 3;              // Sticky CRC error bit.
    localparam int RO_ERR      = 7;              // Readout copy of the error bit.

    localparam logic [LAT_W-1:0] LAT_RST = 8'h08;   // Reset alert latency in core cycles.
    localparam logic             EN_RST  = 1'b0;    // All enables reset off.

    // ==========================================
    // CRC and burst framing.
    // ==========================================
    localparam logic [7:0] CRC_POLY   = 8'h07;   // x^8 + x^2 + x + 1.
    localparam logic [7:0] CRC_INIT   = 8'h00;   // Register seed before bit 71.
    localparam int         LANE_W     = 8;       // Data lines per byte lane.
    localparam int         ROW_BEATS  = 8;       // Tree positions per line.
    localparam int         HALF       = 4;       // Beats in a chopped burst.
    localparam int         TREE_W     = 72;      // Tree inputs per lane.
    localparam logic [3:0] CRC_BEAT   = 4'h8;    // Beat that carries the CRC.
    localparam logic [3:0] BEAT_MAX   = 4'hf;    // Beat counter saturates here.
    localparam logic [3:0] DATA_BEATS = 4'h4;    // Beats of real write data.

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_WAIT  = 3'b010,
        ST_PULSE = 3'b100
    } alert_st_t;

    localparam logic [LAT_W-1:0] PW_LAST = LAT_W'(ALERT_PW_CYC - 1);   // Last count of a pulse.
endpackage

// file: write_crc_check.sv
`timescale 1ns/1ps
module write_crc_check #(
    parameter int LANES = 2
) (
    input  wire logic                                   core_clk_in,
    input  wire logic                                   arst_n_in,
    input  wire logic [3:0]                             avs_address_in,
    input  wire logic                                   avs_read_in,
    input  wire logic                                   avs_write_in,
    input  wire logic [31:0]                            avs_writedata_in,
    output logic      [31:0]                            avs_readdata_out,
    output logic                                        avs_waitrequest_out,
    input  wire logic                                   link_clk_in,
    input  wire logic                                   write_frame_in,
    input  wire logic                                   a2_in,
    input  wire logic [LANES*crc_chk_pkg::LANE_W-1:0]   dq_in,
    input  wire logic [LANES-1:0]                       bus_inversion_flag_n_in,
    input  wire logic                                   alert_in,
    output logic                                        alert_out,
    output logic                                        alert_oe_n_out,
    output logic                                        store_valid_out,
    output logic [LANES*crc_chk_pkg::LANE_W*4-1:0]      store_data_out,
    output logic [LANES*4-1:0]                          write_byte_mask_out
);
    import crc_chk_pkg::*;

    localparam int LW = LANES * LANE_W;      // Bits per beat across all lanes.
    localparam int SW = LW + LANES + 3;      // Width of the synchronised bundle.

    // ==========================================
    // CRC function.
    // ==========================================
    // Bit-serial form of the tree, most significant input first; synthesis flattens it into
    // the same fixed XOR network as a hand-written equation set.
    function automatic logic [7:0] crc8(input logic [TREE_W-1:0] d);
        logic [7:0] c;
        logic       fb;
        c = CRC_INIT;
        fb = 1'b0;
        for (int i = TREE_W - 1; i >= 0; i--) begin
            fb = c[7] ^ d[i];
            c = {c[6:0], 1'b0};
            if (fb) begin
                c = c ^ CRC_POLY;
            end
        end
        return c;
    endfunction

    // ==========================================
    // Declarations.
    // ==========================================
    logic [SW-1:0]         meta_ff;          // First synchroniser stage.
    logic [SW-1:0]         sync_ff;          // Second synchroniser stage.
    logic                  strobe_prev_ff;   // Link clock one sample back.
    logic [1:0]            alert_sync_ff;    // Alert line synchroniser.
    logic [3:0]            beat_ff;          // Beat number within the frame.
    logic [LW*4-1:0]       data_ff;          // Four captured data beats.
    logic [LANES*4-1:0]    pin_ff;           // Pin bit per beat and lane.
    logic                  a2_ff;            // Burst half selector.
    logic [LW-1:0]         crc_rx_ff;        // Received CRC beat.
    logic                  check_ff;         // One-cycle check strobe.
    logic                  crc_en_ff;        // CRC checking enabled.
    logic                  msk_en_ff;        // Byte masking enabled.
    logic                  inv_en_ff;        // Write inversion enabled.
    logic [LAT_W-1:0]      lat_ff;           // Alert latency in core cycles.
    logic                  err_ff;           // Sticky CRC error.
    alert_st_t             st_ff;            // Alert sequencer state.
    alert_st_t             nxt_st;           // Its next value.
    logic [LAT_W-1:0]      cnt_ff;           // Latency or pulse counter.
    logic [LAT_W-1:0]      nxt_cnt;          // Its next value.
    logic                  wait_ff;          // Waitrequest register.
    logic [31:0]           rdata_ff;         // Read data register.
    logic                  alert_oe_n_ff;    // Alert driver enable, active low.
    logic                  store_ff;         // Store strobe register.
    logic [LW*4-1:0]       sdata_ff;         // Store data register.
    logic [LANES*4-1:0]    smask_ff;         // Store mask register.

    logic [LANES-1:0][TREE_W-1:0] tree_in;   // Mapped tree inputs per lane.
    logic [LANES-1:0]             mismatch;  // Lane CRC disagreement.
    logic [LW*4-1:0]              inv_vec;   // Per-bit inversion pattern.

    // ==========================================
    // Link synchronisers.
    // ==========================================
    // Every link input passes two flops; data and strobe share the path so they stay aligned.
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta_ff        <= '0;
            sync_ff        <= '0;
            strobe_prev_ff <= 1'b0;
            alert_sync_ff  <= 2'b11;
        end else begin
            meta_ff        <= {link_clk_in, write_frame_in, a2_in, bus_inversion_flag_n_in, dq_in};
            sync_ff        <= meta_ff;
            strobe_prev_ff <= sync_ff[SW-1];
            alert_sync_ff  <= {alert_sync_ff[0], alert_in};
        end
    end

    wire [LW-1:0]    s_dq     = sync_ff[LW-1:0];        // Synchronised data lines.
    wire [LANES-1:0] s_pin    = sync_ff[LW +: LANES];   // Synchronised pin bits.
    wire             s_a2     = sync_ff[LW + LANES];    // Synchronised burst half.
    wire             s_frame  = sync_ff[LW + LANES + 1];// Synchronised frame.
    wire             s_clk    = sync_ff[SW-1];          // Synchronised link clock.
    wire             rise     = s_clk & ~strobe_prev_ff;// Link clock rising edge.
    wire             take     = rise & s_frame;         // A beat is on the lines.
    wire             data_bt  = take & (beat_ff < DATA_BEATS);
    wire             crc_bt   = take & (beat_ff == CRC_BEAT);

    // ==========================================
    // Beat capture.
    // ==========================================
    // Beats four to seven of a chopped burst carry nothing and are counted but dropped.
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            beat_ff <= '0;
        end else if (!s_frame) begin
            beat_ff <= '0;
        end else if (rise && beat_ff != BEAT_MAX) begin
            beat_ff <= beat_ff + 4'h1;
        end
    end

    // Data, pin bits and the half selector are held for the check after the CRC beat.
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            data_ff   <= '0;
            pin_ff    <= '1;
            a2_ff     <= 1'b0;
            crc_rx_ff <= '0;
            check_ff  <= 1'b0;
        end else begin
            if (data_bt) begin
                data_ff[beat_ff[1:0]*LW +: LW]      <= s_dq;
                pin_ff[beat_ff[1:0]*LANES +: LANES] <= s_pin;
            end
            if (data_bt && beat_ff == '0) begin
                a2_ff <= s_a2;
            end
            if (crc_bt) begin
                crc_rx_ff <= s_dq;
            end
            check_ff <= crc_bt;
        end
    end

    // ==========================================
    // Tree input mapping, one tree per lane.
    // ==========================================
    wire pin_use = msk_en_ff | inv_en_ff;  // Pin row is real data only when a pin function is on.

    for (genvar l = 0; l < LANES; l++) begin : g_lane
        for (genvar b = 0; b <= LANE_W; b++) begin : g_row
            for (genvar k = 0; k < ROW_BEATS; k++) begin : g_pos
                // Positions outside the selected half are constant ones.
                if (b == LANE_W) begin : g_pin
                    assign tree_in[l][b*ROW_BEATS+k] =
                        (a2_ff == (k >= HALF)) ? (pin_use ? pin_ff[(k%HALF)*LANES+l] : 1'b1)
                                               : 1'b1;
                end else begin : g_dq
                    // With A2 set the beats land on the upper nibble positions.
                    assign tree_in[l][b*ROW_BEATS+k] =
                        (a2_ff == (k >= HALF)) ? data_ff[(k%HALF)*LW+l*LANE_W+b] : 1'b1;
                end
            end
        end
        // Each lane gets its own identical tree and compares all eight bits.
        assign mismatch[l] = crc8(tree_in[l]) != crc_rx_ff[l*LANE_W +: LANE_W];
        for (genvar k = 0; k < HALF; k++) begin : g_inv
            // Pin low with inversion on flips the byte, pin high leaves it.
            assign inv_vec[k*LW+l*LANE_W +: LANE_W] = {LANE_W{inv_en_ff & ~pin_ff[k*LANES+l]}};
        end
    end

    wire crc_err  = check_ff & crc_en_ff & (|mismatch);
    wire blocked  = crc_err & msk_en_ff;

    // ==========================================
    // Store path to the array.
    // ==========================================
    // Only the write path exists here; reads never see the inversion logic.
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            store_ff <= 1'b0;
            sdata_ff <= '0;
            smask_ff <= '0;
        end else begin
            store_ff <= check_ff & ~blocked;
            if (check_ff) begin
                sdata_ff <= data_ff ^ inv_vec;
                smask_ff <= msk_en_ff ? ~pin_ff : '0;
            end
        end
    end

    // ==========================================
    // Register bus.
    // ==========================================
    wire req      = avs_read_in | avs_write_in;   // A request is on the bus.
    wire acc      = req & ~wait_ff;               // Edge at which it completes.
    wire sel_ctrl = avs_address_in == OFS_CTRL;
    wire sel_stat = avs_address_in == OFS_STATUS;
    wire sel_ro   = avs_address_in == OFS_READOUT;
    wire wr_ctrl  = acc & avs_write_in & sel_ctrl;
    wire clr_err  = acc & avs_write_in & sel_stat & ~avs_writedata_in[STAT_ERR];

    wire [31:0] ctrl_rd = (32'(lat_ff) << CTRL_LAT_LO) | (32'(inv_en_ff) << CTRL_INV_EN)
                        | (32'(msk_en_ff) << CTRL_MSK_EN) | (32'(crc_en_ff) << CTRL_CRC_EN);
    wire [31:0] stat_rd = (32'(err_ff) << STAT_ERR) | (32'(st_ff != ST_IDLE) << STAT_BUSY)
                        | (32'(alert_sync_ff[1]) << STAT_LINE);
    wire [31:0] ro_rd   = 32'(err_ff) << RO_ERR;
    wire [31:0] rd_mux  = sel_ctrl ? ctrl_rd : sel_stat ? stat_rd : sel_ro ? ro_rd : '0;

    // One wait cycle per access; unmapped reads return zero and writes are dropped.
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wait_ff  <= 1'b1;
            rdata_ff <= '0;
        end else begin
            wait_ff <= ~(req & wait_ff);
            if (req && wait_ff) begin
                rdata_ff <= rd_mux;
            end
        end
    end

    // Control fields steer the tree mapping, masking, inversion and alert timing.
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            crc_en_ff <= EN_RST;
            msk_en_ff <= EN_RST;
            inv_en_ff <= EN_RST;
            lat_ff    <= LAT_RST;
        end else if (wr_ctrl) begin
            crc_en_ff <= avs_writedata_in[CTRL_CRC_EN];
            msk_en_ff <= avs_writedata_in[CTRL_MSK_EN];
            inv_en_ff <= avs_writedata_in[CTRL_INV_EN];
            lat_ff    <= avs_writedata_in[CTRL_LAT_LO +: LAT_W];
        end
    end

    // A new error in the clearing cycle wins, so no report is ever lost.
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            err_ff <= 1'b0;
        end else begin
            err_ff <= crc_err | (err_ff & ~clr_err);
        end
    end

    // ==========================================
    // Alert sequencer.
    // ==========================================
    // Errors arriving while a report is under way only touch the sticky bit; the shared
    // line would merge the pulses anyway, and a short pulse keeps recovery quick.
    always_comb begin
        nxt_st  = st_ff;
        nxt_cnt = cnt_ff;
        case (st_ff)
            ST_IDLE: begin
                if (crc_err) begin
                    nxt_st  = ST_WAIT;
                    nxt_cnt = lat_ff;
                end
            end
            ST_WAIT: begin
                if (cnt_ff == '0) begin
                    nxt_st  = ST_PULSE;
                    nxt_cnt = PW_LAST;
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            ST_PULSE: begin
                if (cnt_ff == '0) begin
                    nxt_st = ST_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            default: begin
                nxt_st  = ST_IDLE;
                nxt_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_ff         <= ST_IDLE;
            cnt_ff        <= '0;
            alert_oe_n_ff <= 1'b1;
        end else begin
            st_ff         <= nxt_st;
            cnt_ff        <= nxt_cnt;
            alert_oe_n_ff <= nxt_st != ST_PULSE;
        end
    end

    // ==========================================
    // Outputs.
    // ==========================================
    // The alert pin is open drain: its data is always low and only the enable moves.
    assign alert_out           = 1'b0;
    assign alert_oe_n_out      = alert_oe_n_ff;
    assign avs_waitrequest_out = wait_ff;
    assign avs_readdata_out    = rdata_ff;
    assign store_valid_out     = store_ff;
    assign store_data_out      = sdata_ff;
    assign write_byte_mask_out = smask_ff;
endmodule

// file: crc_chk_props.sv
`timescale 1ns/1ps
// ==========================================
// Port checker for the write CRC block.
// ==========================================
module crc_chk_props
    import crc_chk_pkg::*;
#(
    parameter int LANES = 2
) (
    input wire logic               core_clk_in,
    input wire logic               arst_n_in,
    input wire logic [3:0]         avs_address_in,
    input wire logic               avs_read_in,
    input wire logic               avs_write_in,
    input wire logic [31:0]        avs_writedata_in,
    input wire logic [31:0]        avs_readdata_out,
    input wire logic               avs_waitrequest_out,
    input wire logic               alert_out,
    input wire logic               alert_oe_n_out,
    input wire logic               store_valid_out,
    input wire logic [LANES*4-1:0] write_byte_mask_out
);
    logic [7:0] lat_ff;   // Latency as last written to the control word.
    logic       msk_ff;   // Byte masking enable as last written.
    logic [8:0] cnt_ff;   // Cycles since the last store pulse, saturating.
    // Shadow of the control word, taken only at a completed write.
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lat_ff <= LAT_RST;
            msk_ff <= EN_RST;
        end else if (avs_write_in && !avs_waitrequest_out && avs_address_in == OFS_CTRL) begin
            lat_ff <= avs_writedata_in[CTRL_LAT_LO+:LAT_W];
            msk_ff <= avs_writedata_in[CTRL_MSK_EN];
        end
    end
    // Starts high so that a pulse before any store is never timed against it.
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) cnt_ff <= 9'h1ff;
        else if (store_valid_out) cnt_ff <= 9'h001;
        else if (cnt_ff != 9'h1ff) cnt_ff <= cnt_ff + 9'h001;
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);
    property p_pulse; $fell(alert_oe_n_out) |=> (!alert_oe_n_out)[*8] ##1 !alert_oe_n_out ##1 alert_oe_n_out; endproperty
    a_pulse: assert property (p_pulse) else $error("alert pulse not ten cycles");
    property p_lat; $fell(alert_oe_n_out) && !msk_ff |-> cnt_ff == {1'b0, lat_ff} + 9'h001; endproperty
    a_lat: assert property (p_lat) else $error("alert pulse at wrong latency");
    property p_block; $fell(alert_oe_n_out) && msk_ff |-> cnt_ff > {1'b0, lat_ff} + 9'h001; endproperty
    a_block: assert property (p_block) else $error("failing burst stored with masking on");
    property p_drive; !alert_oe_n_out |-> !alert_out; endproperty
    a_drive: assert property (p_drive) else $error("alert not pulled low");
    property p_ack; (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out; endproperty
    a_ack: assert property (p_ack) else $error("bus answer late");
    property p_ack1; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
    a_ack1: assert property (p_ack1) else $error("bus answer longer than one cycle");
    property p_store1; store_valid_out |=> !store_valid_out; endproperty
    a_store1: assert property (p_store1) else $error("store pulse too long");
    property p_mask; store_valid_out && !msk_ff |-> write_byte_mask_out == '0; endproperty
    a_mask: assert property (p_mask) else $error("mask set with masking off");
    property p_unmap; avs_read_in && !avs_waitrequest_out && avs_address_in == 4'hc |-> avs_readdata_out == '0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule

// file: ctrl_model.sv
`timescale 1ns/1ps
// ==========================================
// Controller model driving chopped write bursts.
// ==========================================
module ctrl_model (
    input  wire logic        core_clk_in,
    output logic             link_clk_out = 1'b0,
    output logic             frame_out    = 1'b0,
    output logic             a2_out       = 1'b0,
    output logic [15:0]      dq_out       = 16'h0000,
    output logic [1:0]       pin_n_out    = 2'b11
);
    import crc_chk_pkg::*;
    // Eight-bit CRC of one lane's tree, highest index first.
    function automatic logic [7:0] crc8(input logic [71:0] t);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 71; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ t[i]) ? CRC_POLY : 8'h00);
        return c;
    endfunction
    // Half a link period is four core cycles; the strobe only moves inside a frame.
    task automatic tick(input logic lvl);
        repeat (4) @(posedge core_clk_in);
        link_clk_out <= lvl;
    endtask
    // Byte i = beat*2+lane; mode 0 plain, 1 masking, 2 inversion; bad flips one CRC bit.
    task automatic send(input logic [63:0] d, input logic [7:0] m, input logic a2, input logic [1:0] mode,
                        input logic bad);
        logic [63:0] w;
        logic [7:0]  p;
        logic [71:0] t;
        logic [15:0] c;
        for (int i = 0; i < 8; i++) begin
            p[i] = (mode == 2'd2) ? ($countones(d[i*8+:8]) >= 4) : !(mode == 2'd1 && m[i]);
            w[i*8+:8] = (mode == 2'd2 && !p[i]) ? ~d[i*8+:8] : d[i*8+:8];
        end
        for (int l = 0; l < 2; l++) begin
            t = '1;
            for (int k = 0; k < 4; k++) begin
                for (int b = 0; b < 8; b++) t[b*8+k+(a2 ? 4 : 0)] = w[k*16+l*8+b];
                if (mode != 2'd0) t[64+k+(a2 ? 4 : 0)] = p[k*2+l];
            end
            c[l*8+:8] = crc8(t);
        end
        c[8] = c[8] ^ bad;
        // Ten beats: four data, four ignored, the CRC, one ignored.
        for (int j = 0; j < 10; j++) begin
            frame_out <= 1'b1;
            a2_out    <= a2;
            dq_out    <= (j < 4) ? w[j*16+:16] : (j == 8) ? c : ~dq_out;
            pin_n_out <= (j < 4) ? {p[j*2+1], p[j*2]} : ~pin_n_out;
            tick(1'b1);
            tick(1'b0);
        end
        repeat (4) @(posedge core_clk_in);
        // Released data and A2 lines show no stale value; the pin lines keep their last beat.
        frame_out <= 1'b0;
        a2_out    <= ~a2;
        dq_out    <= ~dq_out;
        repeat (16) @(posedge core_clk_in);
    endtask
endmodule

// file: testbench.sv
`timescale 1ns/1ps
`define CHK(a, b, msg) begin checks++; if ((a) !== (b)) begin mismatches++; $display("mismatch %0t %s", $time, msg); end end
// ==========================================
// Self-checking bench for the write CRC block.
// ==========================================
module testbench;
    import crc_chk_pkg::*;
    typedef struct packed {logic [63:0] d; logic [7:0] m;} store_t;
    logic        core_clk = 1'b0;
    logic        arst_n   = 1'b0;
    logic [3:0]  address  = 4'h0;
    logic        read     = 1'b0;
    logic        write    = 1'b0;
    logic [31:0] wdata    = 32'h0;
    logic [31:0] rdata;
    logic        wait_req, link_clk, frame, a2, alert_o, alert_oe_n, st_valid, alert_wire, alert_q = 1'b1;
    logic [15:0] dq;
    logic [1:0]  pin_n;
    logic [63:0] st_data;
    logic [7:0]  st_mask;
    int          mismatches = 0, checks = 0, falls = 0;
    logic [31:0] seed = 32'h5231;
    store_t      exp_st[$];
    logic [63:0] exp_rd[$];
    initial forever #(CLK_NS / 2) core_clk = ~core_clk;
    // The shared alert wire has a pull-up.
    assign alert_wire = alert_oe_n ? 1'b1 : alert_o;
    write_crc_check #(.LANES(2)) i_dut (.core_clk_in(core_clk), .arst_n_in(arst_n), .avs_address_in(address),
        .avs_read_in(read), .avs_write_in(write), .avs_writedata_in(wdata), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wait_req), .link_clk_in(link_clk), .write_frame_in(frame), .a2_in(a2), .dq_in(dq),
        .bus_inversion_flag_n_in(pin_n), .alert_in(alert_wire), .alert_out(alert_o), .alert_oe_n_out(alert_oe_n),
        .store_valid_out(st_valid), .store_data_out(st_data), .write_byte_mask_out(st_mask));
    ctrl_model i_ctrl (.core_clk_in(core_clk), .link_clk_out(link_clk), .frame_out(frame), .a2_out(a2),
        .dq_out(dq), .pin_n_out(pin_n));
    // Next value of the stimulus shift register.
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    // One bus cycle; the request stands until waitrequest is seen low.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        address <= a;
        read    <= !wr;
        write   <= wr;
        wdata   <= d;
        do begin @(posedge core_clk); n++; end while (wait_req !== 1'b0 && n < 50);
        read  <= 1'b0;
        write <= 1'b0;
        @(posedge core_clk);
        `CHK(n < 50, 1'b1, "bus hang")
    endtask
    // Read whose masked value is noted for the monitor.
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_rd.push_back({e, m});
        bus(1'b0, a, 32'h0);
    endtask
    // Monitor: pops the oldest note whenever a result shows.
    always @(posedge core_clk) begin
        logic [63:0] r;
        store_t      s;
        alert_q <= alert_wire;
        if (alert_q === 1'b1 && alert_wire === 1'b0) falls++;
        if (read === 1'b1 && wait_req === 1'b0) begin
            r = exp_rd.pop_front();
            `CHK(rdata & r[31:0], r[63:32], "register read")
        end
        if (st_valid === 1'b1) begin
            s = (exp_st.size() > 0) ? exp_st.pop_front() : '1;
            `CHK(st_data, s.d, "stored data")
            `CHK(st_mask, s.m, "byte mask")
        end
    end
    // Verdict and end of run.
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #(300_000);
        mismatches++;
        end_of_test();
    end
    // Per test: mode (0 plain, 1 masking, 2 inversion), A2, bad CRC, CRC enable and latency.
    localparam logic [1:0] MODES [6] = '{2'd0, 2'd2, 2'd1, 2'd0, 2'd1, 2'd2};
    localparam logic [7:0] LATS  [6] = '{8'h08, 8'h02, 8'h05, 8'h03, 8'h04, 8'h01};
    localparam logic [5:0] A2S = 6'b011010, BADS = 6'b111100, CRCS = 6'b101111;
    initial begin
        logic [63:0] d;
        logic [7:0]  m;
        logic [31:0] cw;
        logic        err;
        int          p;
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        rd(OFS_CTRL, {16'h0, LAT_RST, 8'h00}, 32'h0000_ff07);
        bus(1'b1, 4'hc, 32'hffff_ffff);
        rd(4'hc, 32'h0, 32'hffff_ffff);
        rd(OFS_CTRL, {16'h0, LAT_RST, 8'h00}, 32'h0000_ff07);
        rd(OFS_READOUT, 32'h0, 32'h80);
        for (int s = 0; s < 6; s++) begin
            cw = {16'h0, LATS[s], 5'h0, MODES[s] == 2'd2, MODES[s] == 2'd1, CRCS[s]};
            bus(1'b1, OFS_CTRL, cw);
            rd(OFS_CTRL, cw, 32'h0000_ff07);
            d = {rnd(), rnd()};
            m = 8'(rnd());
            err = BADS[s] && CRCS[s];
            p = falls;
            if (!(err && MODES[s] == 2'd1)) exp_st.push_back({d, (MODES[s] == 2'd1) ? m : 8'h00});
            i_ctrl.send(d, m, A2S[s], MODES[s], BADS[s]);
            repeat (LATS[s] + 12) @(posedge core_clk);
            `CHK(falls - p, int'(err), "alert pulses")
            rd(OFS_STATUS, {28'h0, err, 3'h0}, 32'h8);
            rd(OFS_READOUT, {24'h0, err, 7'h0}, 32'h80);
            bus(1'b1, OFS_STATUS, 32'h8);
            rd(OFS_STATUS, {28'h0, err, 3'h0}, 32'h8);
            bus(1'b1, OFS_STATUS, 32'h0);
            rd(OFS_READOUT, 32'h0, 32'h80);
            // A failed burst is kept and sent again with a good CRC.
            if (err) begin
                exp_st.push_back({d, (MODES[s] == 2'd1) ? m : 8'h00});
                i_ctrl.send(d, m, A2S[s], MODES[s], 1'b0);
                repeat (LATS[s] + 12) @(posedge core_clk);
            end
            `CHK(exp_st.size(), 0, "store count")
            $display("test %0d done", s);
        end
        end_of_test();
    end
endmodule
bind write_crc_check crc_chk_props #(.LANES(LANES)) i_props (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .alert_out(alert_out), .alert_oe_n_out(alert_oe_n_out),
    .store_valid_out(store_valid_out), .write_byte_mask_out(write_byte_mask_out));
